// >>> src/lfcd_decoder.sv
// command decoder of the battery-less transponder
// assumes demodulated bits arrive as pulses and a modulator follows lc_tx
// Notes on behaviour
// - read opcodes return config, serial halves, user words
// - write opcodes store words; 01000 is programming
// - challenge opcodes pick key and cipher
// - opcode 11000 requests a hopping code
// - opcode 11100 selects default communication settings
// - select opcode only with anticollision; 1-25 bits
// - compare only received serial bits; rest wildcard
// - low three serial bits identify the token
// - each clocked one advances token counter from 000
// - counter match plus serial match: acknowledge, selected
// - unselected token stays silent until reselected
// - reset clears selected and unselected state
// - read answer: start pulse, preamble 01, word
// - storage: four user, two serial, one config word
// - write acknowledge only after successful store
// - protected writes need matching 28-bit transport code
// - new config word acts only after reset
// - acknowledge delay follows the memory's own time
// - commands are 5-bit opcode plus data after start
// - all bits travel least significant first
// - time element 200 us or 100 us by baud select
`timescale 1ns/1ps
`default_nettype none
module lfcd_decoder (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // demodulated link from the reader
    input  wire logic                   rx_start,
    input  wire logic                   rx_bit_valid,
    input  wire logic                   rx_bit,
    input  wire logic                   rx_end,
    // nonvolatile words and write port
    input  wire lfcd_pkg::lfcd_words_s  nvm_words,
    input  wire logic [27:0]            transport_code,
    output logic                        nvm_wr_req,
    output lfcd_pkg::lfcd_nvm_wr_s      nvm_wr,
    input  wire logic                   nvm_wr_done,
    input  wire logic                   nvm_wr_ok,
    // cipher and hopping code engines
    output logic                        cipher_req,
    output lfcd_pkg::lfcd_cipher_s      cipher_cmd,
    input  wire logic                   cipher_done,
    input  wire logic [31:0]            cipher_result,
    output logic                        hop_req,
    input  wire logic                   hop_done,
    input  wire logic [31:0]            hop_code,
    output logic                        prog_req,
    // response toward the modulator
    output logic                        lc_tx_active,
    output logic                        lc_tx_level,
    output logic                        lf_time_element,
    // status
    output logic                        token_selected
);
    import lfcd_pkg::*;

    typedef struct packed {
        lfcd_state_e   st;
        logic [5:0]    bcnt;
        logic [4:0]    opc;
        logic [43:0]   data;
        logic          cfg_loaded;
        logic [15:0]   cfg;
        logic          dflt;
        logic          sel_done;
        logic          selected;
        logic          sel_match;
        logic          tok_first;
        logic [2:0]    tok;
        logic          nvm_req;
        lfcd_nvm_wr_s  nvm;
        logic          ciph_req;
        lfcd_cipher_s  ciph;
        logic          hopping_cipher;
        logic          prog;
        logic          push;
        lfcd_resp_s    resp;
        logic [11:0]   te_cnt;
        logic          te_tick;
        logic          tx_busy;
        logic [5:0]    tx_left;
        logic [34:0]   tx_sh;
    } lfcd_state_s;

    localparam lfcd_state_s RESET_STATE = '{
        st: LFCD_IDLE, cfg: CFG_RESET, tx_sh: '1, default: '0};

    lfcd_state_s    q;
    lfcd_state_s    d;
    logic           push_ready;
    logic           pop_valid;
    lfcd_resp_s     pop_data;
    logic           anticol;
    logic           muted;
    logic [11:0]    te_limit;
    logic           frame_end;
    logic [31:0]    serial;

    // opcode low bits map onto the word index of the store
    function automatic logic [2:0] op_addr(input logic [4:0] op);
        return 3'(op[2:0] - 3'h1);
    endfunction

    function automatic logic [15:0] word_at(input lfcd_words_s w,
                                            input logic [2:0] a);
        case (a)
            3'h0:    return w.config_word;
            3'h1:    return w.serial_low_word;
            3'h2:    return w.serial_high_word;
            3'h3:    return w.user_word_0;
            3'h4:    return w.user_word_1;
            3'h5:    return w.user_word_2;
            default: return w.user_word_3;
        endcase
    endfunction

    // the default command overrides the stored options until reset
    assign anticol   = q.cfg[CFG_ANTICOL_BIT] && !q.dflt;
    assign te_limit  = (q.cfg[CFG_BAUD_BIT] && !q.dflt) ?
                       TE_FAST_CYC : TE_SLOW_CYC;
    assign muted     = anticol && q.sel_done && !q.selected;
    assign frame_end = (q.st == LFCD_RX) && rx_end;
    assign serial    = {nvm_words.serial_high_word,
                        nvm_words.serial_low_word};

    always_comb begin
        logic [4:0]  n;
        logic [24:0] mask;
        logic [24:0] got;
        logic [2:0]  tok_n;
        n     = '0;
        mask  = '0;
        got   = '0;
        tok_n = '0;
        d = q;
        d.hopping_cipher     = 1'b0;
        d.prog    = 1'b0;
        d.te_tick = 1'b0;
        // the snapshot makes a freshly written word wait for reset
        if (!q.cfg_loaded) begin
            d.cfg        = nvm_words.config_word;
            d.cfg_loaded = 1'b1;
        end
        if (q.te_cnt >= 12'(te_limit - 12'd1)) begin
            d.te_cnt  = '0;
            d.te_tick = 1'b1;
        end else begin
            d.te_cnt = 12'(q.te_cnt + 12'd1);
        end
        if (q.push && push_ready) begin
            d.push = 1'b0;
        end
        case (q.st)
            LFCD_IDLE, LFCD_TOKEN: begin
                if (rx_start && !q.push) begin
                    d.st   = LFCD_RX;
                    d.bcnt = '0;
                    d.opc  = '0;
                    d.data = '0;
                end else if (q.st == LFCD_TOKEN && rx_bit_valid && rx_bit
                             && !q.push) begin
                    tok_n       = q.tok_first ? 3'h0 : 3'(q.tok + 3'h1);
                    d.tok       = tok_n;
                    d.tok_first = 1'b0;
                    if (q.sel_match &&
                        tok_n == nvm_words.serial_low_word[2:0]) begin
                        d.selected = 1'b1;
                        d.push     = 1'b1;
                        d.resp     = '{len: RESP_ACK, data: '0};
                        d.st       = LFCD_IDLE;
                    end
                end
            end
            LFCD_RX: begin
                if (rx_bit_valid) begin
                    if (q.bcnt < LEN_OPCODE) begin
                        d.opc = {rx_bit, q.opc[4:1]};
                    end else begin
                        d.data = {rx_bit, q.data[43:1]};
                    end
                    if (q.bcnt != 6'h3F) begin
                        d.bcnt = 6'(q.bcnt + 6'd1);
                    end
                end
                if (rx_end) begin
                    d.st = LFCD_IDLE;
                    if (q.opc == OP_SELECT) begin
                        if (anticol && q.bcnt > LEN_OPCODE &&
                            q.bcnt <= LEN_SEL_MAX) begin
                            n    = 5'(q.bcnt - LEN_OPCODE);
                            mask = 25'h1FFFFFF >> (SEL_BITS - n);
                            got  = q.data[43:19] >> (SEL_BITS - n);
                            d.sel_match = ((got ^ serial[27:3]) & mask)
                                          == '0;
                            d.sel_done  = 1'b1;
                            d.selected  = 1'b0;
                            d.tok_first = 1'b1;
                            d.st        = LFCD_TOKEN;
                        end
                    end else if (!muted) begin
                        if (q.opc <= OP_RD_USER_WORD_3) begin
                            if (q.bcnt == LEN_OPCODE) begin
                                d.push = 1'b1;
                                d.resp = '{len: RESP_WORD, data: {16'h0000,
                                         word_at(nvm_words, op_addr(q.opc))}};
                            end
                        end else if (q.opc == OP_PROGRAM) begin
                            d.prog = 1'b1;
                        end else if (q.opc <= OP_WR_USER_WORD_3) begin
                            d.nvm.addr = op_addr(q.opc);
                            d.nvm.data = q.data[43:28];
                            if (q.opc >= OP_WR_USER_WORD_0 &&
                                q.bcnt == LEN_WR_PLAIN) begin
                                d.nvm_req = 1'b1;
                                d.st      = LFCD_NVM;
                            end else if (q.opc <= OP_WR_SER_HI &&
                                         q.bcnt == LEN_WR_PROT &&
                                         q.data[27:0] == transport_code) begin
                                d.nvm_req = 1'b1;
                                d.st      = LFCD_NVM;
                            end
                        end else if ((q.opc == OP_CR_K1_AUT ||
                                      q.opc == OP_CR_K1_HOP ||
                                      q.opc == OP_CR_K2_AUT ||
                                      q.opc == OP_CR_K2_HOP) &&
                                     q.bcnt == LEN_CHAL) begin
                            d.ciph_req       = 1'b1;
                            d.ciph.key_two   = q.opc[2];
                            d.ciph.hop_alg   = q.opc[0];
                            d.ciph.challenge = q.data[43:12];
                            d.st             = LFCD_CIPH;
                        end else if (q.opc == OP_HOP_REQ &&
                                     q.bcnt == LEN_OPCODE) begin
                            d.hopping_cipher = 1'b1;
                            d.st  = LFCD_HOP;
                        end else if (q.opc == OP_DEFAULT &&
                                     q.bcnt == LEN_OPCODE) begin
                            d.dflt = 1'b1;
                        end
                    end
                end
            end
            LFCD_NVM: begin
                // the memory's own write time sets the wait
                if (nvm_wr_done) begin
                    d.nvm_req = 1'b0;
                    d.st      = LFCD_IDLE;
                    if (nvm_wr_ok) begin
                        d.push = 1'b1;
                        d.resp = '{len: RESP_ACK, data: '0};
                    end
                end
            end
            LFCD_CIPH: begin
                if (cipher_done) begin
                    d.ciph_req = 1'b0;
                    d.push     = 1'b1;
                    d.resp     = '{len: RESP_LONG, data: cipher_result};
                    d.st       = LFCD_IDLE;
                end
            end
            LFCD_HOP: begin
                if (hop_done) begin
                    d.push = 1'b1;
                    d.resp = '{len: RESP_LONG, data: hop_code};
                    d.st   = LFCD_IDLE;
                end
            end
            default: begin
                d.st = LFCD_IDLE;
            end
        endcase
        // one element low, preamble 0 then 1, payload from bit 0
        if (!q.tx_busy && pop_valid) begin
            d.tx_busy = 1'b1;
            d.tx_sh   = {pop_data.data, TX_HEAD};
            d.tx_left = (pop_data.len == RESP_ACK) ? 6'd1 :
                        6'(pop_data.len + TX_OVERHEAD);
            // starting at one keeps the first element one long, except when a tick falls in the start cycle and cuts it to one clock
            d.te_cnt  = 12'd1;
        end else if (q.tx_busy && q.te_tick) begin
            d.tx_sh   = {1'b1, q.tx_sh[34:1]};
            d.tx_left = 6'(q.tx_left - 6'd1);
            if (q.tx_left == 6'd1) begin
                d.tx_busy = 1'b0;
                d.tx_sh   = '1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // queue of answers waiting for the modulator; a full queue holds push
    lfcd_fifo #(
        .WIDTH($bits(lfcd_resp_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_resp_fifo (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .in_valid (q.push),
        .in_ready (push_ready),
        .in_data  (q.resp),
        .out_valid(pop_valid),
        .out_ready(!q.tx_busy),
        .out_data (pop_data)
    );

    assign nvm_wr_req      = q.nvm_req;
    assign nvm_wr          = q.nvm;
    assign cipher_req      = q.ciph_req;
    assign cipher_cmd      = q.ciph;
    assign hop_req         = q.hopping_cipher;
    assign prog_req        = q.prog;
    assign lc_tx_active    = q.tx_busy;
    assign lc_tx_level     = q.tx_sh[0];
    assign lf_time_element = q.te_tick;
    assign token_selected  = q.selected;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_read_config: assert property (
        frame_end && q.opc == OP_RD_CFG && q.bcnt == LEN_OPCODE && !muted
        |=> q.push && q.resp.len == RESP_WORD &&
            q.resp.data[15:0] == $past(nvm_words.config_word))
        else $error("config read gave no word");

    a_write_user: assert property (
        frame_end && q.opc == OP_WR_USER_WORD_0 && q.bcnt == LEN_WR_PLAIN && !muted
        |=> q.nvm_req && q.nvm.addr == NVM_ADDR_USER_WORD_0 ##1 q.nvm_req)
        else $error("user write not issued");

    a_chal_key: assert property (
        frame_end && q.opc == OP_CR_K2_HOP && q.bcnt == LEN_CHAL && !muted
        |=> q.ciph_req && q.ciph.key_two && q.ciph.hop_alg)
        else $error("challenge key or cipher wrong");

    a_hop_pulse: assert property (
        frame_end && q.opc == OP_HOP_REQ && q.bcnt == LEN_OPCODE && !muted
        |=> hop_req ##1 !hop_req)
        else $error("hopping request not one pulse");

    a_default_baud: assert property (
        q.dflt |-> te_limit == TE_SLOW_CYC && !anticol)
        else $error("default settings not slow");

    a_select_ack: assert property (
        $rose(q.selected) |-> q.push && q.resp.len == RESP_ACK &&
                              q.tok == nvm_words.serial_low_word[2:0])
        else $error("selection without acknowledge");

    a_muted_quiet: assert property (
        frame_end && muted && q.opc != OP_SELECT
        |=> !q.push && !q.nvm_req && !q.ciph_req && !hop_req)
        else $error("unselected token answered");

    a_bad_code: assert property (
        frame_end && q.opc == OP_WR_CFG && q.data[27:0] != transport_code
        |=> !q.nvm_req && q.st == LFCD_IDLE)
        else $error("write with wrong code issued");

    a_config_held: assert property (
        q.cfg_loaded |=> $stable(q.cfg))
        else $error("config changed before reset");

    a_tx_head: assert property (
        $rose(q.tx_busy) |-> q.tx_sh[2:0] == TX_HEAD && !lc_tx_level)
        else $error("answer lacks start and preamble");

    a_ack_only_ok: assert property (
        q.st == LFCD_NVM && nvm_wr_done && !nvm_wr_ok |=> !q.push)
        else $error("acknowledge after failed write");

    c_select: cover property ($rose(q.selected));
    c_write_ack: cover property (
        q.st == LFCD_NVM && nvm_wr_done && nvm_wr_ok);
    c_challenge: cover property (q.st == LFCD_CIPH && cipher_done);
    c_fifo_full: cover property (q.push && !push_ready);
endmodule // lfcd_decoder
`default_nettype wire

// >>> src/lfcd_fifo.sv
// response queue: width and depth set by parameters
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module lfcd_fifo #(
    parameter int unsigned WIDTH = 38,
    parameter int unsigned DEPTH = 32
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } lfcd_fifo_s;

    lfcd_fifo_s             q;
    lfcd_fifo_s             d;
    logic [WIDTH-1:0]       mem [DEPTH];

    // extra pointer bit tells full from empty
    assign out_valid = q.wr != q.rd;
    assign in_ready  = q.wr != {~q.rd[AW], q.rd[AW-1:0]};
    assign out_data  = mem[q.rd[AW-1:0]];

    always_comb begin
        d = q;
        if (in_valid && in_ready) begin
            d.wr = q.wr + 1'b1;
        end
        if (out_valid && out_ready) begin
            d.rd = q.rd + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
        if (in_valid && in_ready) begin
            mem[q.wr[AW-1:0]] <= in_data;
        end
    end
endmodule // lfcd_fifo
`default_nettype wire

// >>> src/lfcd_pkg.sv
// package of the transponder command decoder: opcodes, timing, frame formats
// assumes a 20 MHz ref_clk and an external demodulator and modulator
package lfcd_pkg;

    localparam int unsigned CLK_FREQ_MHZ = 20;
    localparam int unsigned TE_SLOW_US   = 200;
    localparam int unsigned TE_FAST_US   = 100;
    localparam logic [11:0] TE_SLOW_CYC  = 12'(TE_SLOW_US * CLK_FREQ_MHZ);
    localparam logic [11:0] TE_FAST_CYC  = 12'(TE_FAST_US * CLK_FREQ_MHZ);

    localparam logic [4:0] OP_SELECT    = 5'h00;
    localparam logic [4:0] OP_RD_CFG    = 5'h01;
    localparam logic [4:0] OP_RD_USER_WORD_3   = 5'h07;
    localparam logic [4:0] OP_PROGRAM   = 5'h08;
    localparam logic [4:0] OP_WR_CFG    = 5'h09;
    localparam logic [4:0] OP_WR_SER_HI = 5'h0B;
    localparam logic [4:0] OP_WR_USER_WORD_0   = 5'h0C;
    localparam logic [4:0] OP_WR_USER_WORD_3   = 5'h0F;
    localparam logic [4:0] OP_CR_K1_AUT = 5'h10;
    localparam logic [4:0] OP_CR_K1_HOP = 5'h11;
    localparam logic [4:0] OP_CR_K2_AUT = 5'h14;
    localparam logic [4:0] OP_CR_K2_HOP = 5'h15;
    localparam logic [4:0] OP_HOP_REQ   = 5'h18;
    localparam logic [4:0] OP_DEFAULT   = 5'h1C;

    // frame lengths in bits, opcode included
    localparam logic [5:0] LEN_OPCODE   = 6'd5;
    localparam logic [5:0] LEN_WR_PLAIN = 6'd21;
    localparam logic [5:0] LEN_WR_PROT  = 6'd49;
    localparam logic [5:0] LEN_CHAL     = 6'd37;
    localparam logic [5:0] LEN_SEL_MAX  = 6'd30;
    localparam logic [4:0] SEL_BITS     = 5'd25;

    // response payload lengths; start pulse and preamble add three elements, an acknowledge sends the start pulse alone
    localparam logic [5:0] RESP_ACK     = 6'd0;
    localparam logic [5:0] RESP_WORD    = 6'd16;
    localparam logic [5:0] RESP_LONG    = 6'd32;
    localparam logic [5:0] TX_OVERHEAD  = 6'd3;
    localparam logic [2:0] TX_HEAD      = 3'h4;

    localparam logic [2:0] NVM_ADDR_CFG = 3'h0;
    localparam logic [2:0] NVM_ADDR_USER_WORD_0 = 3'h3;

    localparam int unsigned CFG_BAUD_BIT    = 8;
    localparam int unsigned CFG_ANTICOL_BIT = 9;
    localparam logic [15:0] CFG_RESET       = 16'h0000;
    localparam int unsigned FIFO_DEPTH      = 32;

    typedef enum logic [2:0] {
        LFCD_IDLE, LFCD_RX, LFCD_TOKEN, LFCD_NVM, LFCD_CIPH, LFCD_HOP
    } lfcd_state_e;

    typedef struct packed {
        logic [15:0] config_word;
        logic [15:0] serial_low_word;
        logic [15:0] serial_high_word;
        logic [15:0] user_word_0;
        logic [15:0] user_word_1;
        logic [15:0] user_word_2;
        logic [15:0] user_word_3;
    } lfcd_words_s;

    typedef struct packed {
        logic [5:0]  len;
        logic [31:0] data;
    } lfcd_resp_s;

    typedef struct packed {
        logic        key_two;
        logic        hop_alg;
        logic [31:0] challenge;
    } lfcd_cipher_s;

    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] data;
    } lfcd_nvm_wr_s;

endpackage

// >>> tb/lf_transponder_command_decoder_tb.sv
// self-checking bench of the transponder command decoder
// assumes baud select and anticollision set in the start config word
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    err_total++; $display("wrong value at %0t: got %h want %h", $time, a, b); \
    end end
module lf_transponder_command_decoder_tb;
    import lfcd_pkg::*;
    localparam lfcd_words_s INIT = '{16'h0300, 16'h1235, 16'h5679,
        16'h9ABC, 16'hDEF0, 16'h2468, 16'h1357};
    localparam logic [27:0] CODE = 28'hA5C3E71;
    logic        ref_clk = 1'b0, reset = 1'b1, rx_start = 1'b0;
    logic        rx_bit_valid = 1'b0, rx_bit = 1'b0, rx_end = 1'b0;
    logic        fail_next = 1'b0, wr_q = 1'b0, ci_q = 1'b0, hop_dn = 1'b0;
    logic [7:0]  delay = 8'h03;
    logic [27:0] transport_code = CODE;
    lfcd_words_s  nvm_words;
    lfcd_nvm_wr_s nvm_wr;
    lfcd_cipher_s cipher_cmd;
    logic nvm_wr_req, nvm_wr_done, nvm_wr_ok, cipher_req, hop_req, prog_req;
    logic lc_tx_active, lc_tx_level, lf_time_element, token_selected;
    logic [63:0] expq[$];
    logic [31:0] rng = 32'hc54156cf;
    int          err_total = 0, samples_checked = 0;

    always #25 ref_clk = ~ref_clk;

    lfcd_decoder uut (.ref_clk(ref_clk), .reset(reset), .rx_start(rx_start),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_end(rx_end),
        .nvm_words(nvm_words), .transport_code(transport_code),
        .nvm_wr_req(nvm_wr_req), .nvm_wr(nvm_wr), .nvm_wr_done(nvm_wr_done),
        .nvm_wr_ok(nvm_wr_ok), .cipher_req(cipher_req),
        .cipher_cmd(cipher_cmd), .cipher_done(1'b0),
        .cipher_result(32'h0), .hop_req(hop_req), .hop_done(hop_dn),
        .hop_code(32'h0), .prog_req(prog_req), .lc_tx_active(lc_tx_active),
        .lc_tx_level(lc_tx_level), .lf_time_element(lf_time_element),
        .token_selected(token_selected));
    lfcd_nvm_model #(.INIT(INIT)) nvm (.ref_clk(ref_clk),
        .nvm_wr_req(nvm_wr_req), .nvm_wr(nvm_wr), .nvm_wr_done(nvm_wr_done),
        .nvm_wr_ok(nvm_wr_ok), .nvm_words(nvm_words),
        .fail_next(fail_next), .delay(delay));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction

    // bits go out lowest first, one pulse per bit
    task automatic send(input logic [63:0] v, input int n);
        @(posedge ref_clk) rx_start <= 1'b1;
        @(posedge ref_clk) rx_start <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk) rx_bit_valid <= 1'b1;
            rx_bit <= v[i];
            @(posedge ref_clk) rx_bit_valid <= 1'b0;
        end
        @(posedge ref_clk) rx_end <= 1'b1;
        @(posedge ref_clk) rx_end <= 1'b0;
    endtask

    task automatic note(input logic [63:0] o);
        logic [63:0] e;
        if (expq.size() == 0) begin
            err_total++;
            $display("wrong value at %0t: unexpected %h", $time, o);
        end else begin
            e = expq.pop_front();
            `CHK(o, e)
        end
    endtask

    // edges from one time element pulse to the next
    task automatic te_chk(input int w);
        int n;
        n = 0;
        do @(posedge ref_clk); while (!lf_time_element);
        do begin
            @(posedge ref_clk);
            n++;
        end while (!lf_time_element);
        `CHK(n, w)
    endtask

    task automatic results;
        if (expq.size() != 0) err_total++;
        if (err_total == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        wr_q <= nvm_wr_req;
        ci_q <= cipher_req;
        hop_dn <= hop_req;
        if (nvm_wr_req && !wr_q) note({8'hA0, 37'h0, nvm_wr});
        if (cipher_req && !ci_q) note({8'hC0, 22'h0, cipher_cmd});
        if (prog_req) note({8'hB0, 56'h0});
        if (hop_req) note({8'hE0, 56'h0});
    end

    // sample each answer element in its middle, safe from edge drift
    initial begin : tx_mon
        logic [31:0] b;
        int          n;
        forever begin
            @(posedge lc_tx_active);
            b = '0;
            n = 0;
            forever begin
                repeat (1000) @(posedge ref_clk);
                if (!lc_tx_active) break;
                b[n] = lc_tx_level;
                n++;
                repeat (1000) @(posedge ref_clk);
            end
            note({8'hD0, 8'(n), 16'h0, b});
        end
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        results();
    end

    initial begin : main
        logic [15:0] d;
        logic [31:0] ch;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rng = xs(rng);
        d = rng[15:0];
        delay <= 8'h11;
        expq.push_back({8'hA0, 37'h0, 3'h3, d});
        expq.push_back({8'hD0, 8'h01, 48'h0});
        send({43'h0, d, 5'h0C}, 21);
        repeat (6000) @(posedge ref_clk);
        send({15'h0, d, CODE ^ 28'h0000100, 5'h09}, 49);
        repeat (6000) @(posedge ref_clk);
        fail_next <= 1'b1;
        expq.push_back({8'hA0, 37'h0, 3'h1, d});
        send({15'h0, d, CODE, 5'h0A}, 49);
        repeat (6000) @(posedge ref_clk);
        fail_next <= 1'b0;
        expq.push_back({8'hD0, 8'd19, 16'h0, 13'h0, d, 3'b100});
        send(64'h04, 5);
        repeat (40000) @(posedge ref_clk);
        te_chk(2000);
        // all 25 upper serial bits, then ones up to token five
        expq.push_back({8'hD0, 8'h01, 48'h0});
        send({34'h0, 25'h0CF2246, 5'h00}, 30);
        repeat (6) begin
            @(posedge ref_clk) rx_bit_valid <= 1'b1;
            rx_bit <= 1'b1;
            @(posedge ref_clk) rx_bit_valid <= 1'b0;
        end
        repeat (3100) @(posedge ref_clk);
        `CHK(token_selected, 1'b1)
        expq.push_back({8'hB0, 56'h0});
        send(64'h08, 5);
        repeat (20) @(posedge ref_clk);
        expq.push_back({8'hE0, 56'h0});
        send(64'h18, 5);
        repeat (20) @(posedge ref_clk);
        send(64'h1C, 5);
        te_chk(4000);
        repeat (20) @(posedge ref_clk);
        rng = xs(rng);
        ch = xs(rng);
        // one of the four key and cipher picks, chosen at random
        expq.push_back({8'hC0, 22'h0, rng[2], rng[0], ch});
        send({27'h0, ch, 2'b10, rng[2], 1'b0, rng[0]}, 37);
        repeat (20) @(posedge ref_clk);
        results();
    end
endmodule // lf_transponder_command_decoder_tb
`default_nettype wire

// >>> tb/lfcd_nvm_model.sv
// far-side model: nonvolatile word store behind the decoder's write port
// assumes the bench sets start words, failure flag and write delay
`timescale 1ns/1ps
`default_nettype none
module lfcd_nvm_model #(
    parameter lfcd_pkg::lfcd_words_s INIT = '0
) (
    // clock
    input  wire logic                  ref_clk,
    // write port
    input  wire logic                  nvm_wr_req,
    input  wire lfcd_pkg::lfcd_nvm_wr_s nvm_wr,
    output logic                       nvm_wr_done,
    output logic                       nvm_wr_ok,
    // stored words and test controls
    output lfcd_pkg::lfcd_words_s      nvm_words,
    input  wire logic                  fail_next,
    input  wire logic [7:0]            delay
);
    import lfcd_pkg::*;
    initial begin
        nvm_words   = INIT;
        nvm_wr_done = 1'b0;
        nvm_wr_ok   = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (nvm_wr_req) begin
                // store time varies, so the decoder must wait for done
                repeat (delay) @(posedge ref_clk);
                nvm_wr_ok   <= !fail_next;
                nvm_wr_done <= 1'b1;
                if (!fail_next) begin
                    nvm_words[111-16*nvm_wr.addr -: 16] <= nvm_wr.data;
                end
                @(posedge ref_clk);
                nvm_wr_done <= 1'b0;
            end
        end
    end
endmodule // lfcd_nvm_model
`default_nettype wire
